// ### rtl/uesf_pkg.sv
package uesf_pkg;

  // Endpoint status/control register field positions
  localparam int BIT_STALL_REQUEST = 5;
  localparam int BIT_IN_ARMED      = 4;
  localparam int BIT_STALL_CRC     = 3;
  localparam int BIT_SETUP_RCVD    = 2;
  localparam int BIT_OUT_RCVD      = 1;
  localparam int BIT_IN_COMPLETE   = 0;

  // Register values and masks
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] STATUS_SETUP  = 8'h04;
  localparam logic [7:0] FW_CTRL_MASK  = 8'h30;
  localparam logic [7:0] HW_FLAG_MASK  = 8'h0F;
  localparam logic [7:0] ALL_ONES      = 8'hFF;

  // Endpoint packet size
  localparam int         LEN_W             = 7;
  localparam logic [6:0] MAX_PACKET_LENGTH = 7'h40;
  localparam logic [6:0] LEN_ZERO          = 7'h00;
  localparam logic [6:0] LEN_ONE           = 7'h01;

  // Controller register map (byte offsets on the user port)
  localparam int         ADDR_W        = 4;
  localparam logic [3:0] ADDR_COMMAND  = 4'h0;
  localparam logic [3:0] ADDR_EP_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_CONFIG   = 4'h2;
  localparam logic [3:0] ADDR_LAST     = 4'h3;
  localparam logic [3:0] ADDR_FIFO_WR  = 4'h4;
  localparam logic [3:0] ADDR_FIFO_RD  = 4'h5;

  // Command register bit positions
  localparam int CMD_SETUP   = 0;
  localparam int CMD_OUT     = 1;
  localparam int CMD_OUT_CRC = 2;
  localparam int CMD_IN      = 3;
  localparam int CMD_ACK     = 4;

  // Config register bit positions
  localparam int CFG_ISO = 0;
  localparam int CFG_IE  = 1;

  // Last-reply register bit positions
  localparam int LAST_SENT    = 2;
  localparam int LAST_ZLP     = 3;
  localparam int LAST_ACCEPT  = 4;
  localparam int LAST_REFUSED = 7;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Handshake answered to the host
  typedef enum logic [1:0]
  {
    UESF_RPL_NONE,
    UESF_RPL_ACK,
    UESF_RPL_NAK,
    UESF_RPL_STALL
  } uesf_reply_e;

endpackage

// ### rtl/uesf_if.sv
interface uesf_if
(
  input wire logic ref_clk,
  input wire logic sys_rst
);

  // Firmware side of the endpoint register
  logic                     reg_wr;
  logic [7:0]               reg_wdata;
  logic [7:0]               status;
  logic                     ep_iso;
  logic                     int_enable;
  logic                     ep_irq;
  logic                     fifo_wr;

  // Bus transaction events
  logic                     ev_setup;
  logic                     ev_out;
  logic                     ev_out_crc_err;
  logic                     ev_in;
  logic                     ev_ack;

  // Device answers
  logic                     reply_valid;
  uesf_pkg::uesf_reply_e    reply;
  logic                     in_send;
  logic                     in_zlp;
  logic                     out_accept;

  modport device
  (
    input  ref_clk, sys_rst, reg_wr, reg_wdata, ep_iso, int_enable, fifo_wr,
    input  ev_setup, ev_out, ev_out_crc_err, ev_in, ev_ack,
    output status, ep_irq, reply_valid, reply, in_send, in_zlp, out_accept
  );

  modport host
  (
    input  ref_clk, sys_rst, status, ep_irq, reply_valid, reply, in_send, in_zlp,
    input  out_accept,
    output reg_wr, reg_wdata, ep_iso, int_enable, fifo_wr,
    output ev_setup, ev_out, ev_out_crc_err, ev_in, ev_ack
  );

endinterface

// ### rtl/uesf_device.sv
// Operation
// R1 - Stall request answers next handshake with STALL
// R2 - Firmware arms after loading full IN packet
// R3 - Firmware loads FIFO only while unarmed
// R4 - Armed with empty FIFO sends zero-length packet
// R5 - Armed clears: iso on send, else on ACK
// R6 - Sent STALL sets stall-sent flag, interrupt
// R7 - SETUP clears stall-sent flag
// R8 - Iso CRC error sets bit three, interrupt
// R9 - Iso good CRC clears bit three
// R10 - SETUP sets setup flag, clears all others
// R11 - Firmware clears setup flag after reading payload
// R12 - OUT received sets out flag, interrupt
// R13 - Out flag set: further OUT gets NAK
// R14 - Control SETUP overwrites FIFO despite out flag
// R15 - Firmware clears out flag after reading data
// R16 - Iso IN sets complete flag on send
// R17 - Non-iso IN complete only after host ACK
// R18 - Status register reads zero after reset
// R19 - Flags hold until written zero; set wins
module uesf_device
(
  // Link to the controller
  uesf_if.device lnk
);

  // Endpoint status register
  logic [7:0]              status_q;
  logic [7:0]              status_d;

  // IN packet tracking
  logic                    await_ack_q;
  logic [uesf_pkg::LEN_W-1:0] in_len_q;
  logic                    in_empty;
  logic                    in_full;

  // Registered answers
  logic                    reply_valid_q;
  uesf_pkg::uesf_reply_e   reply_q;
  uesf_pkg::uesf_reply_e   reply_d;
  logic                    in_send_q;
  logic                    in_zlp_q;
  logic                    out_accept_q;

  // Event decode
  logic                    send_in;
  logic                    in_done;
  logic                    accept_out;
  logic                    stall_now;

  // Event decode shared by flag and answer logic
  assign stall_now  = status_q[uesf_pkg::BIT_STALL_REQUEST] & ~lnk.ep_iso;
  assign send_in    = lnk.ev_in & ~lnk.ev_setup & ~lnk.ev_out & ~stall_now
                      & status_q[uesf_pkg::BIT_IN_ARMED];
  assign in_done    = (send_in & lnk.ep_iso)
                      | (lnk.ev_ack & await_ack_q & ~lnk.ev_setup & ~lnk.ev_out
                         & ~lnk.ev_in); // R5 R17
  assign accept_out = lnk.ev_out & ~lnk.ev_setup & ~lnk.ev_out_crc_err & ~stall_now
                      & ~status_q[uesf_pkg::BIT_OUT_RCVD]; // R13

  // Loaded byte count limits
  assign in_empty   = (in_len_q == uesf_pkg::LEN_ZERO);
  assign in_full    = (in_len_q == uesf_pkg::MAX_PACKET_LENGTH);

  // Next value of the status register
  // Firmware write first, then hardware events; setup wins
  always_comb
  begin
    status_d = status_q;
    if (lnk.reg_wr)
    begin
      // Control bits take the write; flags can only be cleared
      status_d = (lnk.reg_wdata & uesf_pkg::FW_CTRL_MASK)
                 | (status_q & lnk.reg_wdata & uesf_pkg::HW_FLAG_MASK); // R19 R1
    end
    if (lnk.ev_setup)
    begin
      status_d = uesf_pkg::STATUS_SETUP; // R10 R7
    end
    else if (lnk.ev_out)
    begin
      if (lnk.ep_iso)
      begin
        status_d[uesf_pkg::BIT_STALL_CRC] = lnk.ev_out_crc_err; // R8 R9
        if (accept_out)
        begin
          status_d[uesf_pkg::BIT_OUT_RCVD] = 1'b1; // R12
        end
      end
      else if (stall_now & ~lnk.ev_out_crc_err)
      begin
        // Corrupt OUT data gets no handshake, so no STALL is sent
        status_d[uesf_pkg::BIT_STALL_CRC] = 1'b1; // R6
      end
      else if (accept_out)
      begin
        status_d[uesf_pkg::BIT_OUT_RCVD] = 1'b1; // R12
      end
    end
    else if (lnk.ev_in & stall_now)
    begin
      status_d[uesf_pkg::BIT_STALL_CRC] = 1'b1; // R6
    end
    if (in_done & ~lnk.ev_setup)
    begin
      status_d[uesf_pkg::BIT_IN_ARMED]    = 1'b0; // R5
      status_d[uesf_pkg::BIT_IN_COMPLETE] = 1'b1; // R16 R17
    end
  end

  // Status register
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      status_q <= uesf_pkg::STATUS_RESET; // R18
    else
      status_q <= status_d;
  end

  // Waiting for the host to acknowledge IN data
  // Any other event but a resent IN ends the wait; the armed bit stays except on SETUP or a lone ACK
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      await_ack_q <= 1'b0;
    else if (send_in & ~lnk.ep_iso)
      await_ack_q <= 1'b1; // R5
    else if (lnk.ev_setup | lnk.ev_out | lnk.ev_in | lnk.ev_ack)
      await_ack_q <= 1'b0;
  end

  // Byte count of the loaded IN packet
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      in_len_q <= uesf_pkg::LEN_ZERO;
    else if (lnk.ev_setup | in_done)
      in_len_q <= uesf_pkg::LEN_ZERO;
    else if (lnk.fifo_wr & ~in_full)
      in_len_q <= in_len_q + uesf_pkg::LEN_ONE; // R3 R2
  end

  // Handshake choice for the current event
  // Priority setup, out, in; isochronous OUT and IN get none
  always_comb
  begin
    reply_d = uesf_pkg::UESF_RPL_NONE;
    if (lnk.ev_setup)
      reply_d = uesf_pkg::UESF_RPL_ACK;
    else if (lnk.ev_out & ~lnk.ep_iso & ~lnk.ev_out_crc_err)
    begin
      if (stall_now)
        reply_d = uesf_pkg::UESF_RPL_STALL; // R1
      else if (accept_out)
        reply_d = uesf_pkg::UESF_RPL_ACK;
      else
        reply_d = uesf_pkg::UESF_RPL_NAK; // R13
    end
    else if (lnk.ev_in & ~lnk.ep_iso)
    begin
      if (stall_now)
        reply_d = uesf_pkg::UESF_RPL_STALL; // R1
      else if (~status_q[uesf_pkg::BIT_IN_ARMED])
        reply_d = uesf_pkg::UESF_RPL_NAK;
    end
  end

  // Handshake answer, one cycle after the event
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
    begin
      reply_valid_q <= 1'b0;
      reply_q       <= uesf_pkg::UESF_RPL_NONE;
    end
    else
    begin
      reply_valid_q <= reply_d != uesf_pkg::UESF_RPL_NONE;
      reply_q       <= reply_d;
    end
  end

  // Data strobes towards the FIFO side
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
    begin
      in_send_q     <= 1'b0;
      in_zlp_q      <= 1'b0;
      out_accept_q  <= 1'b0;
    end
    else
    begin
      in_send_q     <= send_in;
      in_zlp_q      <= send_in & in_empty; // R4
      out_accept_q  <= accept_out | lnk.ev_setup; // R14
    end
  end

  // Register view and interrupt
  assign lnk.status      = status_q & (uesf_pkg::FW_CTRL_MASK | uesf_pkg::HW_FLAG_MASK);
  assign lnk.ep_irq      = lnk.int_enable & |(status_q & uesf_pkg::HW_FLAG_MASK); // R6 R12

  // Answers to the controller
  assign lnk.reply_valid = reply_valid_q;
  assign lnk.reply       = reply_q;
  assign lnk.in_send     = in_send_q;
  assign lnk.in_zlp      = in_zlp_q;
  assign lnk.out_accept  = out_accept_q;

endmodule // uesf_device

// ### rtl/uesf_host.sv
module uesf_host
(
  // Link to the endpoint
  uesf_if.host                    lnk,
  // Register port
  input  wire logic [uesf_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [7:0]         rdata
);

  logic [7:0] rdata_q;
  logic       ev_setup_q;
  logic       ev_out_q;
  logic       ev_crc_q;
  logic       ev_in_q;
  logic       ev_ack_q;
  logic       reg_wr_q;
  logic [7:0] reg_wdata_q;
  logic       iso_q;
  logic       ie_q;
  logic       fifo_wr_q;
  logic [7:0] last_q;
  logic       drained_q;
  logic       refuse_fifo;
  logic       wr_cmd;
  logic       wr_ctrl;
  logic       wr_fifo;
  logic [7:0] keep_mask;

  assign wr_cmd      = wr & (addr == uesf_pkg::ADDR_COMMAND);
  assign wr_ctrl     = wr & (addr == uesf_pkg::ADDR_EP_CTRL);
  assign wr_fifo     = wr & (addr == uesf_pkg::ADDR_FIFO_WR);
  assign refuse_fifo = wr_fifo & lnk.status[uesf_pkg::BIT_IN_ARMED]; // R3

  // Received flags stay set until the FIFO has been read
  always_comb
  begin
    keep_mask = uesf_pkg::BYTE_ZERO;
    if (~drained_q)
    begin
      keep_mask[uesf_pkg::BIT_SETUP_RCVD] = lnk.status[uesf_pkg::BIT_SETUP_RCVD]; // R11
      keep_mask[uesf_pkg::BIT_OUT_RCVD]   = lnk.status[uesf_pkg::BIT_OUT_RCVD]; // R15
    end
  end

  // Bus event pulses
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
    begin
      ev_setup_q <= 1'b0;
      ev_out_q   <= 1'b0;
      ev_crc_q   <= 1'b0;
      ev_in_q    <= 1'b0;
      ev_ack_q   <= 1'b0;
    end
    else
    begin
      ev_setup_q <= wr_cmd & wdata[uesf_pkg::CMD_SETUP];
      ev_out_q   <= wr_cmd & (wdata[uesf_pkg::CMD_OUT] | wdata[uesf_pkg::CMD_OUT_CRC]);
      ev_crc_q   <= wr_cmd & wdata[uesf_pkg::CMD_OUT_CRC];
      ev_in_q    <= wr_cmd & wdata[uesf_pkg::CMD_IN];
      ev_ack_q   <= wr_cmd & wdata[uesf_pkg::CMD_ACK];
    end
  end

  // Firmware writes to the endpoint register and FIFO
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
    begin
      reg_wr_q    <= 1'b0;
      reg_wdata_q <= uesf_pkg::BYTE_ZERO;
      fifo_wr_q   <= 1'b0;
    end
    else
    begin
      reg_wr_q    <= wr_ctrl;
      reg_wdata_q <= wdata | keep_mask; // R2 R4 R1
      fifo_wr_q   <= wr_fifo & ~refuse_fifo; // R3
    end
  end

  // Endpoint configuration
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
    begin
      iso_q <= 1'b0;
      ie_q  <= 1'b0;
    end
    else if (wr & (addr == uesf_pkg::ADDR_CONFIG))
    begin
      iso_q <= wdata[uesf_pkg::CFG_ISO];
      ie_q  <= wdata[uesf_pkg::CFG_IE];
    end
  end

  // FIFO drained since the last received packet
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      drained_q <= 1'b0;
    else if (lnk.out_accept)
      drained_q <= 1'b0;
    else if (rd & (addr == uesf_pkg::ADDR_FIFO_RD))
      drained_q <= 1'b1;
  end

  // Last device answer, refused-write flag where set wins
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      last_q <= uesf_pkg::BYTE_ZERO;
    else
    begin
      if (lnk.reply_valid | lnk.in_send | lnk.out_accept)
      begin
        last_q[1:0]                   <= lnk.reply;
        last_q[uesf_pkg::LAST_SENT]   <= lnk.in_send;
        last_q[uesf_pkg::LAST_ZLP]    <= lnk.in_zlp;
        last_q[uesf_pkg::LAST_ACCEPT] <= lnk.out_accept;
      end
      if (refuse_fifo)
        last_q[uesf_pkg::LAST_REFUSED] <= 1'b1;
      else if (wr & (addr == uesf_pkg::ADDR_LAST))
        last_q[uesf_pkg::LAST_REFUSED] <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge lnk.ref_clk)
  begin
    if (lnk.sys_rst)
      rdata_q <= uesf_pkg::BYTE_ZERO;
    else if (rd)
    begin
      unique case (addr)
        uesf_pkg::ADDR_EP_CTRL: rdata_q <= lnk.status;
        uesf_pkg::ADDR_CONFIG:  rdata_q <= {5'h00, lnk.ep_irq, ie_q, iso_q};
        uesf_pkg::ADDR_LAST:    rdata_q <= last_q;
        uesf_pkg::ADDR_FIFO_RD: rdata_q <= {7'h00, drained_q};
        default:                rdata_q <= uesf_pkg::BYTE_ZERO;
      endcase
    end
    else
      rdata_q <= uesf_pkg::BYTE_ZERO;
  end

  // Outputs
  assign rdata              = rdata_q;
  assign lnk.reg_wr         = reg_wr_q;
  assign lnk.reg_wdata      = reg_wdata_q;
  assign lnk.ep_iso         = iso_q;
  assign lnk.int_enable     = ie_q;
  assign lnk.fifo_wr        = fifo_wr_q;
  assign lnk.ev_setup       = ev_setup_q;
  assign lnk.ev_out         = ev_out_q;
  assign lnk.ev_out_crc_err = ev_crc_q;
  assign lnk.ev_in          = ev_in_q;
  assign lnk.ev_ack         = ev_ack_q;

endmodule // uesf_host

// ### verif/uesf_chk.sv
module uesf_chk
(
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  // Stimulus seen by the endpoint
  input wire logic                  reg_wr,
  input wire logic                  ep_iso,
  input wire logic                  int_enable,
  input wire logic                  ev_setup,
  input wire logic                  ev_out,
  input wire logic                  ev_out_crc_err,
  input wire logic                  ev_in,
  input wire logic                  ev_ack,
  // Endpoint answers
  input wire logic [7:0]            status,
  input wire logic                  ep_irq,
  input wire logic                  reply_valid,
  input wire uesf_pkg::uesf_reply_e reply,
  input wire logic                  in_send,
  input wire logic                  out_accept
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Plain OUT on a non-iso endpoint, no setup beside it
  logic bulk_out;
  assign bulk_out = ev_out && !ev_setup && !ep_iso && !ev_out_crc_err;

  // Link rules
  irq_level_a: assert property (ep_irq == (int_enable && |status[3:0]))
    else $error("irq does not follow flags");
  setup_clears_a: assert property (ev_setup |=> status == uesf_pkg::STATUS_SETUP)
    else $error("setup did not leave setup flag alone");
  setup_accept_a: assert property (ev_setup |=> reply_valid && reply == uesf_pkg::UESF_RPL_ACK
    && out_accept)
    else $error("setup not acked and accepted");
  stall_out_a: assert property (bulk_out && status[5] |=>
    reply == uesf_pkg::UESF_RPL_STALL && status[3])
    else $error("stall request not answered");
  out_nak_a: assert property (bulk_out && !status[5] && status[1] |=>
    reply == uesf_pkg::UESF_RPL_NAK && !out_accept)
    else $error("out accepted while flag set");
  out_take_a: assert property (bulk_out && !status[5] && !status[1] |=>
    status[1] && out_accept)
    else $error("out not taken");
  iso_crc_a: assert property (ev_out && ep_iso && !ev_setup |=>
    status[3] == $past(ev_out_crc_err))
    else $error("iso crc flag wrong");
  iso_in_a: assert property (ev_in && ep_iso && status[4] && !ev_setup && !ev_out |=>
    in_send && !status[4] && status[0])
    else $error("iso in not completed at send");
  bulk_armed_a: assert property (ev_in && !ep_iso && status[4] && !status[5] && !reg_wr
    && !ev_setup && !ev_out |=> in_send && status[4] && $stable(status[0]))
    else $error("bulk in cleared before ack");
  flag_hold_a: assert property (!reg_wr && !ev_setup && !ev_out && !ev_in && !ev_ack |=>
    $stable(status))
    else $error("flags changed on their own");

  // Main scenarios
  cover property (ev_setup ##1 reply == uesf_pkg::UESF_RPL_ACK);
  cover property (bulk_out && status[5]);
  cover property (bulk_out && status[1]);
  cover property (ev_in && ep_iso && status[4]);
endmodule // uesf_chk

// ### verif/uesf_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] CMD = uesf_pkg::ADDR_COMMAND;
  localparam logic [3:0] EPC = uesf_pkg::ADDR_EP_CTRL;
  localparam logic [3:0] CFG = uesf_pkg::ADDR_CONFIG;
  localparam logic [3:0] LST = uesf_pkg::ADDR_LAST;
  localparam logic [3:0] FWR = uesf_pkg::ADDR_FIFO_WR;
  localparam logic [3:0] FRD = uesf_pkg::ADDR_FIFO_RD;

  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] addr    = 4'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] rdata;
  logic [7:0] v;
  int         mismatches = 0;
  int         checked    = 0;
  int         cycles     = 0;

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;

  uesf_if uesf_if_inst (.ref_clk(ref_clk), .sys_rst(sys_rst));
  uesf_device uesf_device_inst (.lnk(uesf_if_inst));
  uesf_host uesf_host_inst
  (
    .lnk   (uesf_if_inst),
    .addr  (addr),
    .wdata (wdata),
    .wr    (wr),
    .rd    (rd),
    .rdata (rdata)
  );
  uesf_chk uesf_chk_inst
  (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .reg_wr         (uesf_if_inst.reg_wr),
    .ep_iso         (uesf_if_inst.ep_iso),
    .int_enable     (uesf_if_inst.int_enable),
    .ev_setup       (uesf_if_inst.ev_setup),
    .ev_out         (uesf_if_inst.ev_out),
    .ev_out_crc_err (uesf_if_inst.ev_out_crc_err),
    .ev_in          (uesf_if_inst.ev_in),
    .ev_ack         (uesf_if_inst.ev_ack),
    .status         (uesf_if_inst.status),
    .ep_irq         (uesf_if_inst.ep_irq),
    .reply_valid    (uesf_if_inst.reply_valid),
    .reply          (uesf_if_inst.reply),
    .in_send        (uesf_if_inst.in_send),
    .out_accept     (uesf_if_inst.out_accept)
  );

  // Verdict and end of run
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle write, then room for the event chain to settle
  task w(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // Read; data stands in the cycle after the strobe
  task r(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // Compare helper
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      mismatches++;
    end
  endtask

  task rc(input logic [3:0] a, input logic [7:0] e, input string n);
    r(a, v);
    chk(n, e, v);
  endtask

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(EPC, 8'h00, "status after reset");
    rc(4'h9, 8'h00, "unmapped read");
    w(CFG, 8'h02);
    // Bulk IN held until ack
    w(FWR, 8'h5A);
    w(EPC, 8'h10);
    rc(EPC, 8'h10, "armed");
    w(CMD, 8'h08);
    rc(LST, 8'h04, "in sent");
    rc(EPC, 8'h10, "armed until ack");
    w(CMD, 8'h10);
    rc(EPC, 8'h01, "in complete after ack");
    rc(CFG, 8'h06, "irq raised");
    w(EPC, 8'h00);
    rc(EPC, 8'h00, "flag cleared by zero");
    // Zero-length packet
    w(EPC, 8'h10);
    w(CMD, 8'h08);
    rc(LST, 8'h0C, "zlp sent");
    w(CMD, 8'h10);
    rc(EPC, 8'h01, "zlp complete");
    // Load refused while armed
    w(EPC, 8'h10);
    w(FWR, 8'hA5);
    r(LST, v);
    chk("refused load", 8'h80, v & 8'h80);
    w(LST, 8'h00);
    // Setup wipes all others
    w(CMD, 8'h01);
    rc(EPC, 8'h04, "setup status");
    rc(LST, 8'h11, "setup ack");
    w(EPC, 8'h00);
    rc(EPC, 8'h04, "setup kept unread");
    r(FRD, v);
    w(EPC, 8'h00);
    rc(EPC, 8'h00, "setup cleared");
    // OUT then NAK, then early setup
    w(CMD, 8'h02);
    rc(EPC, 8'h02, "out flag");
    rc(LST, 8'h11, "out acked");
    w(CMD, 8'h02);
    rc(LST, 8'h02, "out nak");
    w(CMD, 8'h01);
    rc(LST, 8'h11, "setup over out");
    r(FRD, v);
    w(EPC, 8'h00);
    w(CMD, 8'h02);
    r(FRD, v);
    w(EPC, 8'h00);
    rc(EPC, 8'h00, "out cleared");
    // Stall on IN and OUT, cleared by setup
    w(EPC, 8'h20);
    w(CMD, 8'h06);
    rc(EPC, 8'h20, "bad crc out no stall");
    w(CMD, 8'h08);
    rc(LST, 8'h03, "stall on in");
    rc(EPC, 8'h28, "stall sent");
    w(CMD, 8'h02);
    rc(LST, 8'h03, "stall on out");
    w(CMD, 8'h01);
    rc(EPC, 8'h04, "stall flag cleared");
    r(FRD, v);
    w(EPC, 8'h00);
    // Isochronous endpoint
    w(CFG, 8'h03);
    w(CMD, 8'h06);
    rc(EPC, 8'h08, "crc error");
    w(CMD, 8'h02);
    rc(EPC, 8'h02, "crc cleared");
    r(FRD, v);
    w(EPC, 8'h10);
    w(CMD, 8'h08);
    rc(EPC, 8'h01, "iso complete");
    // Reset in mid-run
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(EPC, 8'h00, "status after second reset");
    give_verdict();
  end
endmodule // tb
